// >>> src/lms_consts.svh
// constants for the lighting mode sequencer
// assumes a single 40 MHz system clock
`ifndef LMS_CONSTS_SVH
`define LMS_CONSTS_SVH

`define LMS_CLK_HZ          40000000
`define LMS_OSC_HZ          1000000
`define LMS_OSC_DIV         (`LMS_CLK_HZ / `LMS_OSC_HZ)
`define LMS_STARTUP_MS      10
`define LMS_SOFTSTART_MS    20
`define LMS_STARTUP_TICKS   ((`LMS_STARTUP_MS * `LMS_OSC_HZ) / 1000)
`define LMS_SOFTSTART_TICKS ((`LMS_SOFTSTART_MS * `LMS_OSC_HZ) / 1000)
`define LMS_VOUT_RESET      8'h08
`define LMS_VOUT_MIN        8'h08
`define LMS_VOUT_MAX        8'h14

`endif

// >>> src/lms_pkg.sv
// types for the lighting mode sequencer
// assumes nothing of its surroundings
package lms_pkg;
    typedef enum logic [2:0] {
        LMS_RESET      = 3'h0,
        LMS_STANDBY    = 3'h1,
        LMS_STARTUP    = 3'h3,
        LMS_BOOST_SS   = 3'h2,
        LMS_NORMAL     = 3'h6
    } lms_state_t;
endpackage : lms_pkg

// >>> src/lms_osc_tick.sv
// oscillator tick divider for the lighting mode sequencer
// assumes clk_sys runs at LMS_CLK_HZ; tick scales with div
`timescale 1ns/1ps
module lms_osc_tick #(
    parameter int unsigned DIV = 40
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        next_tick;

    always_comb begin
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (!run) begin
            next_cnt = 16'h0000;
        end else if (cnt == 16'(DIV - 1)) begin
            next_cnt  = 16'h0000;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : lms_osc_tick

// >>> src/lms_sequencer.sv
// operating mode sequencer: reset, standby, startup, boost soft start, normal
// assumes register bits arrive as synchronous levels from the serial port
`include "lms_consts.svh"
`timescale 1ns/1ps

// Summary of operation
// - in reset state every control register returns to its default
// - reset state entered while external reset low or power-on reset active
// - release of power-on reset leads to standby, not operation
// - run request bit defaults to zero after power-on reset
// - standby with everything off while run request zero and no reset
// - writes accepted in standby; settings apply as soon as startup ends
// - run request starts internal startup with a 10 ms settling delay
// - overtemperature disables operation and holds startup until it clears
// - boost soft start runs 20 ms at low current with LEDs forced off
// - soft start entered from startup or from normal when boost enabled
// - normal mode applies any register write, any bits, immediately
// - boost enable low puts converter in standby; high reruns soft start
// - active discharge on only while the boost converter runs and the autoload enable bit is set
// - 8-bit voltage code, clamped to thirteen levels 8 V to 20 V
// - all delays counted in internal oscillator ticks
module lms_sequencer #(
    parameter int unsigned OSC_DIV         = `LMS_OSC_DIV,
    parameter int unsigned STARTUP_TICKS   = `LMS_STARTUP_TICKS,
    parameter int unsigned SOFTSTART_TICKS = `LMS_SOFTSTART_TICKS
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       ext_reset_n,
    input  wire logic       por_active,
    input  wire logic       overtemp_shutdown,
    input  wire logic       wr_en,
    input  wire logic       run_request_wr,
    input  wire logic       boost_enable_wr,
    input  wire logic       autoload_enable_wr,
    input  wire logic [7:0] vout_code_wr,
    output logic            run_request_bit,
    output logic            boost_enable,
    output logic            autoload_enable,
    output logic [7:0]      vout_code,
    output logic [4:0]      vout_level,
    output logic            regs_in_reset,
    output logic            core_powered,
    output logic            boost_run,
    output logic            boost_soft_start,
    output logic            discharge_on,
    output logic            led_enable,
    output logic [2:0]      mode
);
    // ****************************************
    // oscillator tick
    // ****************************************
    logic osc_tick;
    logic osc_run;

    lms_osc_tick #(.DIV(OSC_DIV)) u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (osc_run),
        .tick    (osc_tick)
    );

    // ****************************************
    // control registers
    // ****************************************
    logic       in_reset;
    logic       next_run;
    logic       next_boost;
    logic       next_autoload;
    logic [7:0] next_vout;

    assign in_reset = !ext_reset_n || por_active;

    always_comb begin
        next_run      = run_request_bit;
        next_boost    = boost_enable;
        next_autoload = autoload_enable;
        next_vout     = vout_code;
        if (in_reset) begin
            next_run      = 1'b0;
            next_boost    = 1'b0;
            next_autoload = 1'b1;
            next_vout     = `LMS_VOUT_RESET;
        end else if (wr_en) begin
            next_run      = run_request_wr;
            next_boost    = boost_enable_wr;
            next_autoload = autoload_enable_wr;
            next_vout     = vout_code_wr;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_request_bit <= 1'b0;
            boost_enable    <= 1'b0;
            autoload_enable <= 1'b1;
            vout_code       <= `LMS_VOUT_RESET;
        end else begin
            run_request_bit <= next_run;
            boost_enable    <= next_boost;
            autoload_enable <= next_autoload;
            vout_code       <= next_vout;
        end
    end

    // clamp to 8..20 V; level 0 means 8 V
    always_comb begin
        if (vout_code < `LMS_VOUT_MIN) begin
            vout_level = 5'h00;
        end else if (vout_code > `LMS_VOUT_MAX) begin
            vout_level = 5'(`LMS_VOUT_MAX - `LMS_VOUT_MIN);
        end else begin
            vout_level = 5'(vout_code - `LMS_VOUT_MIN);
        end
    end

    // ****************************************
    // mode state machine
    // ****************************************
    lms_pkg::lms_state_t state;
    lms_pkg::lms_state_t next_state;
    logic [15:0]         delay;
    logic [15:0]         next_delay;
    logic                boost_prev;
    logic                boost_rise;

    assign boost_rise = boost_enable && !boost_prev;
    assign osc_run    = state != lms_pkg::LMS_RESET && state != lms_pkg::LMS_STANDBY;

    always_comb begin
        next_state = state;
        next_delay = delay;
        if (in_reset) begin
            next_state = lms_pkg::LMS_RESET;
            next_delay = 16'h0000;
        end else begin
            unique case (state)
                lms_pkg::LMS_RESET: begin
                    next_state = lms_pkg::LMS_STANDBY;
                end
                lms_pkg::LMS_STANDBY: begin
                    next_delay = 16'h0000;
                    if (run_request_bit) begin
                        next_state = lms_pkg::LMS_STARTUP;
                    end
                end
                lms_pkg::LMS_STARTUP: begin
                    if (!run_request_bit) begin
                        next_state = lms_pkg::LMS_STANDBY;
                    end else if (overtemp_shutdown) begin
                        next_delay = 16'h0000;
                    end else if (osc_tick) begin
                        if (delay == 16'(STARTUP_TICKS - 1)) begin
                            next_delay = 16'h0000;
                            next_state = boost_enable ? lms_pkg::LMS_BOOST_SS
                                                      : lms_pkg::LMS_NORMAL;
                        end else begin
                            next_delay = delay + 16'h0001;
                        end
                    end
                end
                lms_pkg::LMS_BOOST_SS: begin
                    if (!run_request_bit) begin
                        next_state = lms_pkg::LMS_STANDBY;
                    end else if (overtemp_shutdown) begin
                        next_state = lms_pkg::LMS_STARTUP;
                        next_delay = 16'h0000;
                    end else if (!boost_enable) begin
                        next_state = lms_pkg::LMS_NORMAL;
                        next_delay = 16'h0000;
                    end else if (osc_tick) begin
                        if (delay == 16'(SOFTSTART_TICKS - 1)) begin
                            next_delay = 16'h0000;
                            next_state = lms_pkg::LMS_NORMAL;
                        end else begin
                            next_delay = delay + 16'h0001;
                        end
                    end
                end
                lms_pkg::LMS_NORMAL: begin
                    next_delay = 16'h0000;
                    if (!run_request_bit) begin
                        next_state = lms_pkg::LMS_STANDBY;
                    end else if (overtemp_shutdown) begin
                        next_state = lms_pkg::LMS_STARTUP;
                    end else if (boost_rise) begin
                        next_state = lms_pkg::LMS_BOOST_SS;
                    end
                end
                default: begin
                    next_state = lms_pkg::LMS_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state      <= lms_pkg::LMS_RESET;
            delay      <= 16'h0000;
            boost_prev <= 1'b0;
        end else begin
            state      <= next_state;
            delay      <= next_delay;
            boost_prev <= boost_enable;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic active;
    assign active           = state == lms_pkg::LMS_BOOST_SS || state == lms_pkg::LMS_NORMAL;
    assign regs_in_reset    = state == lms_pkg::LMS_RESET;
    assign core_powered     = osc_run;
    assign boost_run        = active && boost_enable;
    // soft start only while the converter is enabled; cleared enable means standby
    assign boost_soft_start = state == lms_pkg::LMS_BOOST_SS && boost_enable;
    assign discharge_on     = boost_run && autoload_enable;
    assign led_enable       = state == lms_pkg::LMS_NORMAL;
    assign mode             = state;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_reset_entry: assert property (!ext_reset_n |=> state == lms_pkg::LMS_RESET)
        else $error("reset not entered");
    a_reset_to_standby: assert property (state == lms_pkg::LMS_RESET && !in_reset
        |=> state == lms_pkg::LMS_STANDBY)
        else $error("reset did not go to standby");
    a_reset_defaults: assert property (in_reset |=> !run_request_bit && autoload_enable
        && vout_code == `LMS_VOUT_RESET)
        else $error("defaults not restored");
    a_run_default: assert property ($rose(rst_n) |-> !run_request_bit)
        else $error("run request not zero");
    a_standby_off: assert property (state == lms_pkg::LMS_STANDBY |-> !core_powered
        && !boost_run && !led_enable)
        else $error("standby not quiet");
    a_standby_write: assert property (state == lms_pkg::LMS_STANDBY && wr_en && !in_reset
        |=> boost_enable == $past(boost_enable_wr))
        else $error("standby write lost");
    a_startup_go: assert property (state == lms_pkg::LMS_STANDBY && run_request_bit
        && !in_reset |=> state == lms_pkg::LMS_STARTUP)
        else $error("startup not begun");
    a_overtemp_hold: assert property (overtemp_shutdown && run_request_bit && !in_reset
        && state != lms_pkg::LMS_RESET && state != lms_pkg::LMS_STANDBY
        |=> state == lms_pkg::LMS_STARTUP)
        else $error("overtemp not held");
    a_ss_leds_off: assert property (boost_soft_start |-> !led_enable && boost_run)
        else $error("leds on in soft start");
    a_boost_rerun: assert property (state == lms_pkg::LMS_NORMAL && boost_rise
        && run_request_bit && !overtemp_shutdown && !in_reset
        |=> state == lms_pkg::LMS_BOOST_SS)
        else $error("soft start not rerun");
    a_boost_off: assert property (!boost_enable |-> !boost_run && !discharge_on)
        else $error("boost running while disabled");
    a_discharge: assert property (boost_run |-> discharge_on == autoload_enable)
        else $error("discharge path wrong");
    a_vout_clamp: assert property (vout_level <= 5'h0C)
        else $error("voltage level out of range");
    a_ss_done: assert property (boost_soft_start && osc_tick && boost_enable
        && run_request_bit && !overtemp_shutdown && !in_reset
        && delay == 16'(SOFTSTART_TICKS - 1) |=> led_enable)
        else $error("soft start did not finish");

    c_startup: cover property (state == lms_pkg::LMS_STARTUP ##1 state == lms_pkg::LMS_NORMAL);
    c_soft: cover property (boost_soft_start ##1 led_enable);
    c_rerun: cover property (led_enable ##1 boost_soft_start);
    c_overtemp: cover property (led_enable && overtemp_shutdown);
endmodule : lms_sequencer

// >>> verification/lms_host_model.sv
// host model: loads all control fields with a one-cycle write strobe
// assumes the bench calls its tasks and clk_sys runs at 40 MHz
`timescale 1ns/1ps
module lms_host_model (
    input  wire logic       clk_sys,
    output logic            wr_en,
    output logic            run_wr,
    output logic            boost_wr,
    output logic            aload_wr,
    output logic [7:0]      code_wr
);
    initial begin
        wr_en = 1'b0;
        run_wr = 1'b0;
        boost_wr = 1'b0;
        aload_wr = 1'b0;
        code_wr = 8'h00;
    end

    // fields held with the strobe, scrambled once it drops
    task automatic write_regs(input logic run, input logic boost, input logic aload,
                              input logic [7:0] code);
        @(posedge clk_sys);
        #1;
        wr_en = 1'b1;
        run_wr = run;
        boost_wr = boost;
        aload_wr = aload;
        code_wr = code;
        @(posedge clk_sys);
        #1;
        wr_en = 1'b0;
        run_wr = ~run;
        boost_wr = ~boost;
        aload_wr = ~aload;
        code_wr = ~code;
    endtask : write_regs

    // no load: converter stopped at the lowest voltage
    task automatic park(input logic run);
        write_regs(run, 1'b0, 1'b1, 8'h08);
    endtask : park
endmodule : lms_host_model

// >>> verification/lms_sequencer_tb.sv
// self-checking bench for the lighting mode sequencer
// assumes shortened delays: 4 clocks per tick, 5 and 8 ticks
`timescale 1ns/1ps
module lms_sequencer_tb;
    localparam int div = 4;
    localparam int st = 5;
    localparam int ss = 8;
    localparam logic [2:0] md_rst = lms_pkg::LMS_RESET;
    localparam logic [2:0] md_stby = lms_pkg::LMS_STANDBY;
    localparam logic [2:0] md_start = lms_pkg::LMS_STARTUP;
    localparam logic [2:0] md_ss = lms_pkg::LMS_BOOST_SS;
    localparam logic [2:0] md_norm = lms_pkg::LMS_NORMAL;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       ext_reset_n = 1'b1;
    logic       por_active = 1'b1;
    logic       overtemp_shutdown = 1'b0;
    logic       wr_en, run_wr, boost_wr, aload_wr;
    logic [7:0] code_wr, vout_code;
    logic       run_request_bit, boost_enable, autoload_enable, regs_in_reset;
    logic       core_powered, boost_run, boost_soft_start, discharge_on, led_enable;
    logic [4:0] vout_level;
    logic [2:0] mode;
    int         failures = 0;
    int         cmp_count = 0;
    int         n;
    logic [7:0] codes [7] = '{8'h00, 8'h07, 8'h08, 8'h0D, 8'h14, 8'h15, 8'hFF};

    always #12.5 clk_sys = ~clk_sys;

    lms_host_model i_host (.clk_sys(clk_sys), .wr_en(wr_en), .run_wr(run_wr),
        .boost_wr(boost_wr), .aload_wr(aload_wr), .code_wr(code_wr));

    lms_sequencer #(.OSC_DIV(div), .STARTUP_TICKS(st), .SOFTSTART_TICKS(ss)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
        .por_active(por_active), .overtemp_shutdown(overtemp_shutdown),
        .wr_en(wr_en), .run_request_wr(run_wr), .boost_enable_wr(boost_wr),
        .autoload_enable_wr(aload_wr), .vout_code_wr(code_wr),
        .run_request_bit(run_request_bit), .boost_enable(boost_enable),
        .autoload_enable(autoload_enable), .vout_code(vout_code),
        .vout_level(vout_level), .regs_in_reset(regs_in_reset),
        .core_powered(core_powered), .boost_run(boost_run),
        .boost_soft_start(boost_soft_start), .discharge_on(discharge_on),
        .led_enable(led_enable), .mode(mode));

    // ****************************************
    // helpers
    // ****************************************
    task automatic step(input int k = 1);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_mode(input logic [2:0] m, input int lim, output int k);
        k = 0;
        while (mode !== m && k < lim) begin
            step();
            k++;
        end
        if (mode !== m) begin
            failures++;
            $display("ERROR %0t: mode %0h not reached", $time, m);
            tally_and_finish();
        end
    endtask : wait_mode

    // delay in clocks from one tick under to one tick plus 3 clocks over its nominal length
    task automatic chk_len(input int k, input int ticks);
        chk(16'((k >= (ticks - 1) * div) && (k <= (ticks + 1) * div + 3)), 16'h0001);
    endtask : chk_len

    // ****************************************
    // tests
    // ****************************************
    initial begin
        step(8);
        rst_n = 1'b1;
        step(3);
        chk(16'(mode), 16'(md_rst));
        chk(16'(regs_in_reset), 16'h0001);
        por_active = 1'b0;
        step(2);
        chk(16'(mode), 16'(md_stby));
        chk(16'(run_request_bit), 16'h0000);
        chk(16'({autoload_enable, vout_code}), 16'h0108);
        chk(16'({core_powered, boost_run, led_enable}), 16'h0000);
        $display("done: reset");
        i_host.write_regs(1'b0, 1'b1, 1'b1, 8'h14);
        step(4);
        chk(16'(mode), 16'(md_stby));
        chk(16'(boost_enable), 16'h0001);
        i_host.write_regs(1'b1, 1'b1, 1'b1, 8'h14);
        wait_mode(md_start, 10, n);
        chk(16'(core_powered), 16'h0001);
        wait_mode(md_ss, 200, n);
        chk_len(n, st);
        chk(16'({boost_soft_start, led_enable, vout_level}), 16'h004C);
        wait_mode(md_norm, 200, n);
        chk_len(n, ss);
        chk(16'({led_enable, boost_run, discharge_on}), 16'h0007);
        $display("done: startup");
        i_host.write_regs(1'b1, 1'b1, 1'b0, 8'h14);
        step();
        chk(16'(discharge_on), 16'h0000);
        foreach (codes[i]) begin
            i_host.write_regs(1'b1, 1'b1, 1'b1, codes[i]);
            step();
            chk(16'(vout_code), 16'(codes[i]));
            chk(16'(vout_level), 16'(codes[i] < 8'h08 ? 8'h00 :
                codes[i] > 8'h14 ? 8'h0C : codes[i] - 8'h08));
        end
        $display("done: voltage");
        i_host.park(1'b1);
        step(2);
        chk(16'({mode, boost_run, led_enable}), 16'({md_norm, 2'b01}));
        i_host.write_regs(1'b1, 1'b1, 1'b1, 8'h08);
        wait_mode(md_ss, 5, n);
        chk(16'({led_enable, boost_soft_start}), 16'h0001);
        wait_mode(md_norm, 200, n);
        chk_len(n, ss);
        i_host.park(1'b1);
        i_host.write_regs(1'b1, 1'b1, 1'b1, 8'h08);
        wait_mode(md_ss, 5, n);
        i_host.write_regs(1'b1, 1'b0, 1'b1, 8'h08);
        step();
        chk(16'({mode, boost_soft_start, boost_run}), 16'({md_norm, 2'b00}));
        $display("done: boost restart");
        overtemp_shutdown = 1'b1;
        wait_mode(md_start, 5, n);
        i_host.park(1'b1);
        step(60);
        chk(16'({mode, led_enable}), 16'({md_start, 1'b0}));
        overtemp_shutdown = 1'b0;
        wait_mode(md_norm, 200, n);
        chk_len(n, st);
        chk(16'(boost_run), 16'h0000);
        $display("done: overtemp");
        ext_reset_n = 1'b0;
        step(2);
        chk(16'(mode), 16'(md_rst));
        i_host.write_regs(1'b1, 1'b1, 1'b0, 8'h14);
        step();
        chk(16'({run_request_bit, boost_enable, autoload_enable, vout_code}), 16'h0108);
        ext_reset_n = 1'b1;
        step(2);
        chk(16'({mode, led_enable}), 16'({md_stby, 1'b0}));
        $display("done: external reset");
        tally_and_finish();
    end
endmodule : lms_sequencer_tb
